// >>> eid_params.svh
`ifndef EID_PARAMS_SVH
`define EID_PARAMS_SVH

// Register byte offsets on the AHB-Lite slave.
`define EID_OFF_CTRL      12'h000
`define EID_OFF_ENABLE    12'h004
`define EID_OFF_FLAGS     12'h008
`define EID_OFF_VECTOR    12'h00c
`define EID_OFF_IRQ_STAT  12'h010
`define EID_OFF_IRQ_MASK  12'h014

// Control register fields.
`define EID_CTRL_TTS0     0
`define EID_CTRL_TTS1     1
`define EID_CTRL_WIDTH    2

// Request flag / enable positions, one bit per source, in polling order.
`define EID_SRC_EXT0      0
`define EID_SRC_TMR0      1
`define EID_SRC_EXT1      2
`define EID_SRC_TMR1      3
`define EID_NUM_SRC       4

// Global enable bit in the enable register.
`define EID_EN_GLOBAL     7

// Service vectors.
`define EID_VEC_EXT0      16'h0003
`define EID_VEC_TMR0      16'h000b
`define EID_VEC_EXT1      16'h0013
`define EID_VEC_TMR1      16'h001b

// Status register bits.
`define EID_ST_EXT0       0
`define EID_ST_EXT1       1
`define EID_ST_WIDTH      2

// Machine cycle length in system clocks.
`define EID_MC_CLKS       12

// Reset values.
`define EID_CTRL_RST      2'h0
`define EID_EN_RST        8'h00
`define EID_MASK_RST      2'h0

`endif

// >>> eid_pkg.sv
package eid_pkg;

  typedef enum logic [1:0] {
    EID_ST_IDLE    = 2'b00,
    EID_ST_SERVICE = 2'b01,
    EID_ST_RETURN  = 2'b11
  } eid_state_type;

  typedef logic [15:0] eid_vector_type;

endpackage

// >>> eid_edge_detect.sv
`timescale 1ns/1ns
`include "eid_params.svh"

// Samples an active-low request pin and produces the raw request condition.
module eid_edge_detect (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  input  wire logic edge_mode,
  output logic      level_req,
  output logic      fall_seen
);

  logic prev_q;

  // -----------------------------------------------------------------------
  // Sampling
  // -----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= pin;
    end
  end

  assign level_req = ~pin & ~edge_mode;
  assign fall_seen = prev_q & ~pin & edge_mode;

endmodule

// >>> eid_poll_select.sv
`timescale 1ns/1ns
`include "eid_params.svh"

// Fixed-order selection among pending, enabled requests.
module eid_poll_select (
  input  wire logic [`EID_NUM_SRC-1:0] active,
  output logic                         any,
  output logic [1:0]                   winner,
  output eid_pkg::eid_vector_type      vector
);

  function automatic eid_pkg::eid_vector_type vec_of(input logic [1:0] s);
    case (s)
      2'd0:    vec_of = `EID_VEC_EXT0;
      2'd1:    vec_of = `EID_VEC_TMR0;
      2'd2:    vec_of = `EID_VEC_EXT1;
      default: vec_of = `EID_VEC_TMR1;
    endcase
  endfunction

  assign any    = |active;
  // Lowest index wins, so timer 0 comes ahead of timer 1.
  assign winner = active[0] ? 2'd0 :
                  active[1] ? 2'd1 :
                  active[2] ? 2'd2 : 2'd3;
  assign vector = vec_of(winner);

endmodule

// >>> eid_core.sv
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
`include "eid_params.svh"

// Contract
// - Level mode raises request on low pin.
// - Edge mode sets flag on high-then-low samples.
// - Edge flag cleared automatically on vectoring.
// - Level pin still low re-interrupts after return.
// - Flag interrupts only when its enable set; the irq line ignores the enables and is gated by mask_q.
// - Software-set flag acts like hardware-set flag.
// - Fixed polling order, timer 0 before timer 1.
// - One instruction runs after return before next.
// - Vectors 0003H and 0013H for external inputs.
// - Inverted pin latched into flag every clock in level mode.
module eid_core (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        haddr_sel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        ext_interrupt_pin_0_n,
  input  wire logic        ext_interrupt_pin_1_n,
  input  wire logic        timer0_overflow_flag_set,
  input  wire logic        timer1_overflow_flag_set,
  input  wire logic        cpu_accept,
  input  wire logic        return_from_interrupt,
  input  wire logic        instr_done,
  output logic             cpu_request,
  output eid_pkg::eid_vector_type cpu_vector,
  output logic             irq
);

  // -----------------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------------
  logic [`EID_CTRL_WIDTH-1:0] ctrl_q;
  logic [7:0]                 en_q;
  logic [`EID_NUM_SRC-1:0]    flag_q;
  logic [`EID_NUM_SRC-1:0]    flag_d;
  logic [`EID_ST_WIDTH-1:0]   stat_q;
  logic [`EID_ST_WIDTH-1:0]   mask_q;
  eid_pkg::eid_vector_type    vec_q;
  eid_pkg::eid_state_type     state_q;
  eid_pkg::eid_state_type     state_d;
  logic                       wr_pend_q;
  logic [11:0]                wr_addr_q;
  logic [31:0]                rdata_q;

  // -----------------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------------
  // Offset match, shared by the write strobes and the read selection.
  function automatic logic off_is(input logic [11:0] off, input logic [11:0] reg_off);
    off_is = (off == reg_off);
  endfunction

  wire        addr_ph   = haddr_sel & htrans[1] & hready;
  wire        wr_start  = addr_ph & hwrite;
  wire        rd_start  = addr_ph & ~hwrite;
  wire [11:0] a_off     = haddr[11:0];
  wire        wr_ctrl   = wr_pend_q & off_is(wr_addr_q, `EID_OFF_CTRL);
  wire        wr_en     = wr_pend_q & off_is(wr_addr_q, `EID_OFF_ENABLE);
  wire        wr_flags  = wr_pend_q & off_is(wr_addr_q, `EID_OFF_FLAGS);
  wire        wr_stat   = wr_pend_q & off_is(wr_addr_q, `EID_OFF_IRQ_STAT);
  wire        wr_mask   = wr_pend_q & off_is(wr_addr_q, `EID_OFF_IRQ_MASK);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // Unmapped offsets read as zero, so software may probe the map safely.
  wire [31:0] rd_mux =
    off_is(a_off, `EID_OFF_CTRL)     ? {30'h0, ctrl_q} :
    off_is(a_off, `EID_OFF_ENABLE)   ? {24'h0, en_q} :
    off_is(a_off, `EID_OFF_FLAGS)    ? {28'h0, flag_q} :
    off_is(a_off, `EID_OFF_VECTOR)   ? {16'h0, vec_q} :
    off_is(a_off, `EID_OFF_IRQ_STAT) ? {30'h0, stat_q} :
    off_is(a_off, `EID_OFF_IRQ_MASK) ? {30'h0, mask_q} : 32'h0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= wr_start;
    end
  end

  // The address is kept for the data phase, when hwdata stands.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_addr_q <= 12'h000;
    end else begin
      wr_addr_q <= a_off;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_start) begin
      rdata_q <= rd_mux;
    end
  end

  // -----------------------------------------------------------------------
  // Pin detection
  // -----------------------------------------------------------------------
  logic lvl0;
  logic lvl1;
  logic fall0;
  logic fall1;

  eid_edge_detect u_det0 (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin       (ext_interrupt_pin_0_n),
    .edge_mode (ctrl_q[`EID_CTRL_TTS0]),
    .level_req (lvl0),
    .fall_seen (fall0)
  );

  eid_edge_detect u_det1 (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin       (ext_interrupt_pin_1_n),
    .edge_mode (ctrl_q[`EID_CTRL_TTS1]),
    .level_req (lvl1),
    .fall_seen (fall1)
  );

  // -----------------------------------------------------------------------
  // Request flags
  // -----------------------------------------------------------------------
  wire [1:0] ext_edge  = {ctrl_q[`EID_CTRL_TTS1], ctrl_q[`EID_CTRL_TTS0]};
  wire [1:0] ext_lvl   = {lvl1, lvl0};
  wire [1:0] ext_fall  = {fall1, fall0};
  wire [3:0] hw_set    = {timer1_overflow_flag_set, ext_fall[1],
                          timer0_overflow_flag_set, ext_fall[0]};
  logic       any_act;
  logic [1:0] winner;
  logic [1:0] ext_next;
  eid_pkg::eid_vector_type win_vec;

  wire       take      = cpu_request & cpu_accept;
  // Only the poll winner is taken, so only its flag may be cleared.
  wire [3:0] ack_clr   = take ? (4'h1 << winner) : 4'h0;

  // The external flags in level mode are rebuilt every clock from the
  // pin, so a short pulse is lost and a held low re-requests after return.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ext
      localparam int SRC = (g == 0) ? `EID_SRC_EXT0 : `EID_SRC_EXT1;
      wire sw_set   = wr_flags & hwdata[SRC];
      wire held     = wr_flags ? hwdata[SRC] : flag_q[SRC];
      // A new falling edge wins over the clear of the same cycle.
      wire on_edge  = (held & ~ack_clr[SRC]) | ext_fall[g];
      wire on_level = ext_lvl[g] | sw_set;
      assign ext_next[g] = ext_edge[g] ? on_edge : on_level;
    end
  endgenerate

  always_comb begin
    flag_d = flag_q;
    if (wr_flags) begin
      flag_d = hwdata[`EID_NUM_SRC-1:0];
    end
    // Timer flags clear when taken; a new overflow wins over that clear.
    flag_d = (flag_d & ~ack_clr) | hw_set;
    flag_d[`EID_SRC_EXT0] = ext_next[0];
    flag_d[`EID_SRC_EXT1] = ext_next[1];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_q <= 4'h0;
    end else begin
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= `EID_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= hwdata[`EID_CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_q <= `EID_EN_RST;
    end else if (wr_en) begin
      en_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_q <= `EID_MASK_RST;
    end else if (wr_mask) begin
      mask_q <= hwdata[`EID_ST_WIDTH-1:0];
    end
  end

  // -----------------------------------------------------------------------
  // Polling and vectoring
  // -----------------------------------------------------------------------
  wire [3:0] active = flag_q & en_q[3:0] & {4{en_q[`EID_EN_GLOBAL]}};

  eid_poll_select u_poll (
    .active (active),
    .any    (any_act),
    .winner (winner),
    .vector (win_vec)
  );

  // A write to the enable register blocks the request for one clock; a return blocks it until instr_done.
  wire blocked = (state_q != eid_pkg::EID_ST_IDLE) | wr_en;

  always_comb begin
    state_d = state_q;
    case (state_q)
      eid_pkg::EID_ST_IDLE: begin
        if (take) begin
          state_d = eid_pkg::EID_ST_SERVICE;
        end
      end
      eid_pkg::EID_ST_SERVICE: begin
        if (return_from_interrupt) begin
          state_d = eid_pkg::EID_ST_RETURN;
        end
      end
      eid_pkg::EID_ST_RETURN: begin
        if (instr_done) begin
          state_d = eid_pkg::EID_ST_IDLE;
        end
      end
      default: state_d = eid_pkg::EID_ST_IDLE;
    endcase
  end

  assign cpu_request = any_act & ~blocked;
  assign cpu_vector  = vec_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= eid_pkg::EID_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // The vector is registered, so it trails the poll winner by one clock.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vec_q <= 16'h0000;
    end else begin
      vec_q <= win_vec;
    end
  end

  // -----------------------------------------------------------------------
  // Status and interrupt line
  // -----------------------------------------------------------------------
  wire [1:0] ev = {flag_d[`EID_SRC_EXT1] & ~flag_q[`EID_SRC_EXT1],
                   flag_d[`EID_SRC_EXT0] & ~flag_q[`EID_SRC_EXT0]};
  wire [1:0] st_clr = wr_stat ? hwdata[`EID_ST_WIDTH-1:0] : 2'b00;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_q <= 2'b00;
    end else begin
      stat_q <= (stat_q & ~st_clr) | ev;
    end
  end

  assign irq = |(stat_q & mask_q);

endmodule

// >>> eid_monitor.sv
`timescale 1ns/1ns
`include "eid_params.svh"
// -------------------------------------------------------------
// Port checks, with shadows of the enable and mask writes.
// -------------------------------------------------------------
module eid_monitor (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    haddr_sel,
  input wire logic [31:0]             haddr,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic [31:0]             hwdata,
  input wire logic                    hready,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire logic                    ext_interrupt_pin_0_n,
  input wire logic                    cpu_accept,
  input wire logic                    return_from_interrupt,
  input wire logic                    instr_done,
  input wire logic                    cpu_request,
  input wire eid_pkg::eid_vector_type cpu_vector,
  input wire logic                    irq
);
  logic [11:0] wa_q;
  logic        wr_q;
  logic [7:0]  en_q;
  logic [1:0]  mask_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q   <= 1'b0;
      wa_q   <= 12'h000;
      en_q   <= 8'h00;
      mask_q <= 2'h0;
    end else begin
      if (hready) begin
        wr_q <= haddr_sel && htrans[1] && hwrite;
        wa_q <= haddr[11:0];
      end
      if (wr_q && wa_q == `EID_OFF_ENABLE) en_q <= hwdata[7:0];
      if (wr_q && wa_q == `EID_OFF_IRQ_MASK) mask_q <= hwdata[1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_ret_wait;
    return_from_interrupt ##1 !instr_done;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready OKAY");
  a_reset_quiet: assert property ($rose(rst_n) |-> !irq && !cpu_request)
    else $error("outputs active after reset");
  a_req_enabled: assert property (cpu_request |-> en_q[`EID_EN_GLOBAL] && en_q[3:0] != 4'h0)
    else $error("request while disabled");
  a_accept_blocks: assert property (cpu_accept |=> !cpu_request)
    else $error("request during service");
  a_ret_blocks: assert property (return_from_interrupt |=> !cpu_request)
    else $error("request right after return");
  a_ret_waits: assert property (s_ret_wait |=> !cpu_request)
    else $error("request before next instruction");
  a_vector_known: assert property (cpu_request [*2] |-> cpu_vector inside
    {`EID_VEC_EXT0, `EID_VEC_TMR0, `EID_VEC_EXT1, `EID_VEC_TMR1})
    else $error("vector outside table");
  a_irq_masked: assert property (irq |-> (mask_q | $past(mask_q)) != 2'h0)
    else $error("irq with mask clear");
  a_fall_irq: assert property (mask_q[0] && $fell(ext_interrupt_pin_0_n) |-> ##[1:3] irq)
    else $error("pin fall gave no irq");
endmodule
bind eid_core eid_monitor u_mon (.clk, .rst_n, .haddr_sel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hresp, .ext_interrupt_pin_0_n, .cpu_accept, .return_from_interrupt,
  .instr_done, .cpu_request, .cpu_vector, .irq);

// >>> eid_src.sv
`timescale 1ns/1ns
`include "eid_params.svh"
// -------------------------------------------------------------
// External request source, moving its pin only after a full hold.
// -------------------------------------------------------------
module eid_src #(
  parameter int HOLD = `EID_MC_CLKS
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic want_low,
  output logic      pin_n
);
  logic       pin_q;
  logic [4:0] cnt_q;
  assign pin_n = pin_q;
  // A shorter level could fall between two samples and be lost.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_q <= 1'b1;
      cnt_q <= 5'h00;
    end else if (want_low == pin_q && cnt_q >= 5'(HOLD - 1)) begin
      pin_q <= ~want_low;
      cnt_q <= 5'h00;
    end else if (cnt_q != 5'h1f) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
endmodule

// >>> testbench.sv
`timescale 1ns/1ns
`include "eid_params.svh"
// -------------------------------------------------------------
// Directed checks of detection, gating, polling and the irq line.
// -------------------------------------------------------------
module testbench;
  logic        clk = 1'b0, rst_n = 1'b0, haddr_sel = 1'b0, hwrite = 1'b0, t0_set = 1'b0;
  logic        t1_set = 1'b0;
  logic        want0 = 1'b0, want1 = 1'b0, cpu_accept = 1'b0;
  logic        return_from_interrupt = 1'b0, instr_done = 1'b0;
  logic        hreadyout, hresp, pin0_n, pin1_n, cpu_request, irq;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  eid_pkg::eid_vector_type cpu_vector;
  int          err_count = 0, n_tests = 0;
  eid_core u_dut (.clk, .rst_n, .haddr_sel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_interrupt_pin_0_n(pin0_n),
    .ext_interrupt_pin_1_n(pin1_n), .timer0_overflow_flag_set(t0_set),
    .timer1_overflow_flag_set(t1_set), .cpu_accept, .return_from_interrupt, .instr_done,
    .cpu_request, .cpu_vector, .irq);
  eid_src u_src0 (.clk, .rst_n, .want_low(want0), .pin_n(pin0_n));
  eid_src u_src1 (.clk, .rst_n, .want_low(want1), .pin_n(pin1_n));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr_sel <= 1'b1;
    htrans    <= 2'b10;
    hwrite    <= w;
    haddr     <= {20'h00000, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    haddr_sel <= 1'b0;
    htrans    <= 2'b00;
    hwdata    <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic strobe(input logic [2:0] s);
    @(posedge clk);
    {cpu_accept, return_from_interrupt, instr_done} <= s;
    @(posedge clk);
    {cpu_accept, return_from_interrupt, instr_done} <= 3'b000;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic test_regs;
    bus(1'b0, `EID_OFF_IRQ_MASK, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 12'h020, 32'hffffffff);
    bus(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `EID_OFF_CTRL, 32'h3);
    bus(1'b0, `EID_OFF_CTRL, 32'h0);
    chk(rd, 32'h3);
    $display("test regs done");
  endtask
  task automatic test_level;
    bus(1'b1, `EID_OFF_CTRL, 32'h0);
    bus(1'b1, `EID_OFF_ENABLE, 32'h81);
    want0 <= 1'b1;
    settle(16);
    chk_bit(cpu_request, 1'b1);
    chk({16'h0, cpu_vector}, {16'h0, `EID_VEC_EXT0});
    bus(1'b0, `EID_OFF_VECTOR, 32'h0);
    chk(rd, {16'h0, `EID_VEC_EXT0});
    strobe(3'b100);
    settle(0);
    chk_bit(cpu_request, 1'b0);
    strobe(3'b010);
    settle(0);
    chk_bit(cpu_request, 1'b0);
    strobe(3'b001);
    settle(1);
    chk_bit(cpu_request, 1'b1);
    @(posedge clk);
    want0 <= 1'b0;
    settle(16);
    chk_bit(cpu_request, 1'b0);
    $display("test level done");
  endtask
  task automatic test_edge;
    bus(1'b1, `EID_OFF_CTRL, 32'h2);
    bus(1'b1, `EID_OFF_ENABLE, 32'h84);
    want1 <= 1'b1;
    settle(16);
    @(posedge clk);
    want1 <= 1'b0;
    settle(16);
    chk_bit(cpu_request, 1'b1);
    chk({16'h0, cpu_vector}, {16'h0, `EID_VEC_EXT1});
    strobe(3'b100);
    bus(1'b0, `EID_OFF_FLAGS, 32'h0);
    chk(rd, 32'h0);
    strobe(3'b010);
    strobe(3'b001);
    $display("test edge done");
  endtask
  task automatic test_poll;
    bus(1'b1, `EID_OFF_ENABLE, 32'h80);
    bus(1'b1, `EID_OFF_FLAGS, 32'h8);
    t0_set <= 1'b1;
    @(posedge clk);
    t0_set <= 1'b0;
    settle(2);
    chk_bit(cpu_request, 1'b0);
    bus(1'b0, `EID_OFF_FLAGS, 32'h0);
    chk(rd, 32'ha);
    bus(1'b1, `EID_OFF_ENABLE, 32'h8a);
    settle(2);
    chk({16'h0, cpu_vector}, {16'h0, `EID_VEC_TMR0});
    strobe(3'b100);
    strobe(3'b010);
    strobe(3'b001);
    settle(2);
    chk_bit(cpu_request, 1'b1);
    chk({16'h0, cpu_vector}, {16'h0, `EID_VEC_TMR1});
    strobe(3'b100);
    strobe(3'b010);
    strobe(3'b001);
    t1_set <= 1'b1;
    @(posedge clk);
    t1_set <= 1'b0;
    bus(1'b0, `EID_OFF_FLAGS, 32'h0);
    chk(rd, 32'h8);
    $display("test poll done");
  endtask
  task automatic test_irq;
    bus(1'b1, `EID_OFF_ENABLE, 32'h0);
    bus(1'b1, `EID_OFF_CTRL, 32'h0);
    bus(1'b1, `EID_OFF_IRQ_STAT, 32'h3);
    bus(1'b1, `EID_OFF_IRQ_MASK, 32'h1);
    want0 <= 1'b1;
    settle(16);
    chk_bit(irq, 1'b1);
    bus(1'b1, `EID_OFF_IRQ_MASK, 32'h0);
    settle(1);
    chk_bit(irq, 1'b0);
    bus(1'b1, `EID_OFF_IRQ_MASK, 32'h1);
    settle(1);
    chk_bit(irq, 1'b1);
    bus(1'b1, `EID_OFF_IRQ_STAT, 32'h1);
    settle(1);
    chk_bit(irq, 1'b0);
    $display("test irq done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    test_regs;
    test_level;
    test_edge;
    test_poll;
    test_irq;
    give_verdict;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict;
  end
endmodule
